// ==== holdoff_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "irq_pin_defines.svh"

// Free-running 10 us step generator
module holdoff_tick
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      tick
);

	logic [11:0] cnt_r; // Cycle counter within one step

	// Pulse tick once per step; restart realigns the step
	always_ff @(posedge core_clk)
	begin
		if (rst || restart || tick)
			cnt_r <= 12'h000;
		else
			cnt_r <= cnt_r + 12'h001;
	end

	assign tick = (cnt_r == 12'(`TICK_CYCLES - 1));

endmodule : holdoff_tick
`default_nettype wire

// ==== irq_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host interrupt input with pull-up
module irq_host_model
(
	input  wire logic oe,
	input  wire logic o,
	output logic      pin
);
	assign pin = oe ? o : 1'b1;
endmodule : irq_host_model
`default_nettype wire

// ==== irq_pin_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "irq_pin_defines.svh"

// Notes on behaviour
// - Bits 31:24 set hold-off in 10us steps
// - Zero interval disables hold-off, forwards pending
// - New interval applies to later interrupts
// - Writing bit 14 restarts interval, self-clears
// - Bit 13 reads one during hold-off
// - Bit 12 shows internal master line
// - Bit 8 zero keeps pin de-asserted
// - Bit 4 selects active high polarity
// - Bit 0 selects push-pull, else open-drain
// - Open-drain always signals active low
// - Polarity, drive bits survive soft reset
// - Master line ORs enabled status bits
module irq_pin_ctrl
	import irq_pin_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        soft_rst,
	input  wire reg_req_t    req,
	output logic [31:0]      rdata,
	input  wire logic [31:0] interrupt_source_status,
	input  wire logic [31:0] interrupt_source_enable,
	input  wire logic        irq_pin_i,
	output logic             irq_pin_o,
	output logic             irq_pin_oe
);

	// Software-visible configuration
	logic [7:0]     deassert_holdoff_interval_r;
	logic           irq_out_enable_r;
	logic           interrupt_pin_polarity_r;
	logic           push_pull_drive_r;
	// Hold-off engine
	holdoff_state_t state_r;
	holdoff_state_t state_nxt;
	logic [7:0]     holdoff_cnt_r;
	logic [7:0]     holdoff_cnt_nxt;
	logic           master_line;
	logic           cfg_wr;
	logic           cfg_sel;         // Address hits the config register
	logic           holdoff_interval_restart;
	logic           tick;
	logic           pin_asserted;
	logic           level_active;
	logic [7:0]     new_interval;
	logic           holdoff_interval_active;
	logic [31:0]    rdata_nxt;

	// Pin level is not observed internally; the wire is only driven
	logic           unused_pin;
	assign unused_pin = irq_pin_i;

	// Register select and write decode, shared by read and write paths
	assign cfg_sel      = (req.addr == `IRQ_CFG_OFFSET);
	assign cfg_wr       = req.wr && cfg_sel;
	assign new_interval = req.wdata[`CFG_HOLDOFF_MSB:`CFG_HOLDOFF_LSB];
	assign holdoff_interval_restart = cfg_wr && req.wdata[`CFG_RESTART_BIT];

	assign master_line = |(interrupt_source_status & interrupt_source_enable);

	// Step timer, realigned on restart so the first step is whole
	// 10us step timer
	holdoff_tick holdoff_tick_inst
	(
		.core_clk (core_clk),
		.rst      (rst),
		.restart  (holdoff_interval_restart),
		.tick     (tick)
	);

	// Configuration bits cleared by chip reset and soft reset
	always_ff @(posedge core_clk)
	begin
		if (rst || soft_rst)
		begin
			deassert_holdoff_interval_r <= `HOLDOFF_RESET;
			irq_out_enable_r            <= 1'b0;
		end
		else if (cfg_wr)
		begin
			deassert_holdoff_interval_r <= new_interval;
			irq_out_enable_r            <= req.wdata[`CFG_OUT_EN_BIT];
		end
	end

	// Pin shape bits: soft reset deliberately ignored
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			interrupt_pin_polarity_r <= 1'b0;
			push_pull_drive_r        <= 1'b0;
		end
		else if (cfg_wr)
		begin
			interrupt_pin_polarity_r <= req.wdata[`CFG_POL_BIT];
			push_pull_drive_r        <= req.wdata[`CFG_DRIVE_BIT];
		end
	end

	// Hold-off sequencer; the interval value is sampled when a hold-off
	// starts, so a nonzero rewrite without bit 14 only affects later interrupts
	always_comb
	begin
		state_nxt       = state_r;
		holdoff_cnt_nxt = holdoff_cnt_r;
		case (state_r)
			// Interrupts pass to the pin
			ST_PASS:
			begin
				if (master_line)
					state_nxt = ST_ASSERTED;
			end
			// Pin asserted; watch for return to inactive
			ST_ASSERTED:
			begin
				if (!master_line && (deassert_holdoff_interval_r != 8'h00))
				begin
					state_nxt       = ST_HOLDOFF;
					holdoff_cnt_nxt = deassert_holdoff_interval_r;
				end
				else if (!master_line)
					state_nxt = ST_PASS;
			end
			// Counting down in 10 us steps, interrupts withheld
			ST_HOLDOFF:
			begin
				if (tick && (holdoff_cnt_r == 8'h01))
				begin
					state_nxt       = ST_PASS;
					holdoff_cnt_nxt = 8'h00;
				end
				else if (tick)
					holdoff_cnt_nxt = holdoff_cnt_r - 8'h01;
			end
			default:
			begin
				state_nxt       = ST_PASS;
				holdoff_cnt_nxt = 8'h00;
			end
		endcase
		if (holdoff_interval_restart && (new_interval != 8'h00))
		begin
			state_nxt       = ST_HOLDOFF;
			holdoff_cnt_nxt = new_interval;
		end
		if (cfg_wr && (new_interval == 8'h00))
		begin
			state_nxt       = master_line ? ST_ASSERTED : ST_PASS;
			holdoff_cnt_nxt = 8'h00;
		end
		// Chip or soft reset returns to pass
		if (rst || soft_rst)
		begin
			state_nxt       = ST_PASS;
			holdoff_cnt_nxt = 8'h00;
		end
	end

	// Sequencer state registers
	always_ff @(posedge core_clk)
	begin
		state_r       <= state_nxt;
		holdoff_cnt_r <= holdoff_cnt_nxt;
	end

	assign holdoff_interval_active = (state_r == ST_HOLDOFF);
	assign pin_asserted = irq_out_enable_r && master_line && !holdoff_interval_active;

	assign level_active = push_pull_drive_r ? interrupt_pin_polarity_r : 1'b0;

	// Pin drive, registered to keep the pin glitch-free
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			irq_pin_o  <= 1'b1;
			irq_pin_oe <= 1'b0;
		end
		else if (push_pull_drive_r)
		begin
			irq_pin_o  <= pin_asserted ? level_active : !level_active;
			irq_pin_oe <= 1'b1;
		end
		else
		begin
			// Open-drain: drive low only while asserted
			irq_pin_o  <= 1'b0;
			irq_pin_oe <= pin_asserted;
		end
	end

	// Read data assembly; restart bit always reads zero
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (cfg_sel)
		begin
			rdata_nxt[`CFG_HOLDOFF_MSB:`CFG_HOLDOFF_LSB] = deassert_holdoff_interval_r;
			rdata_nxt[`CFG_ACTIVE_BIT]                   = holdoff_interval_active;
			rdata_nxt[`CFG_MASTER_BIT]                   = master_line;
			rdata_nxt[`CFG_OUT_EN_BIT]                   = irq_out_enable_r;
			rdata_nxt[`CFG_POL_BIT]                      = interrupt_pin_polarity_r;
			rdata_nxt[`CFG_DRIVE_BIT]                    = push_pull_drive_r;
		end
	end

	// Read data held in a flop, updated on each read
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata <= 32'h0000_0000;
		else if (req.rd)
			rdata <= rdata_nxt;
	end

endmodule : irq_pin_ctrl
`default_nettype wire

// ==== irq_pin_defines.svh ====
`ifndef IRQ_PIN_DEFINES_SVH
`define IRQ_PIN_DEFINES_SVH

// Register location
`define IRQ_CFG_OFFSET        12'h054
// Field positions
`define CFG_HOLDOFF_MSB       31
`define CFG_HOLDOFF_LSB       24
`define CFG_RESTART_BIT       14
`define CFG_ACTIVE_BIT        13
`define CFG_MASTER_BIT        12
`define CFG_OUT_EN_BIT        8
`define CFG_POL_BIT           4
`define CFG_DRIVE_BIT         0
// Reset values
`define HOLDOFF_RESET         8'h00
// Timing: one hold-off step in ns, clock period in ns
`define HOLDOFF_STEP_NS       10000
`define CLK_PERIOD_NS         4
`define TICK_CYCLES           (`HOLDOFF_STEP_NS / `CLK_PERIOD_NS)

`endif

// ==== irq_pin_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// Checks config readback and pin levels
module irq_pin_monitor
	import irq_pin_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        soft_rst,
	input  wire reg_req_t    req,
	input  wire logic [31:0] rdata,
	input  wire logic [31:0] interrupt_source_status,
	input  wire logic [31:0] interrupt_source_enable,
	input  wire logic        irq_pin_i,
	input  wire logic        irq_pin_o,
	input  wire logic        irq_pin_oe
);
	// Shadow {interval, enable, polarity, drive}
	logic [10:0] s_r, s1_r, s2_r;
	logic        m1_r, m2_r;
	wire         m = |(interrupt_source_status & interrupt_source_enable);
	wire         rd_cfg = req.rd && req.addr == 12'h054;
	// Stable over the two-stage pin pipeline
	wire         calm = s_r == s1_r && s_r == s2_r;
	wire         on = calm && s_r[2] && s_r[10:3] == 8'h00 && m && m1_r && m2_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Soft reset keeps polarity and drive only
	always_ff @(posedge core_clk)
	begin
		if (rst)
			{s_r, s1_r, s2_r, m1_r, m2_r} <= '0;
		else
		begin
			if (soft_rst)
				s_r <= {9'h000, s_r[1:0]};
			else if (req.wr && req.addr == 12'h054)
				s_r <= {req.wdata[31:24], req.wdata[8], req.wdata[4], req.wdata[0]};
			{s2_r, s1_r, m2_r, m1_r} <= {s1_r, s_r, m1_r, m};
		end
	end
	property p_cfg; rd_cfg |=> {rdata[31:24], rdata[8], rdata[4], rdata[0]} == $past(s_r); endproperty
	a_cfg: assert property (p_cfg) else $error("config readback");
	property p_resv; rd_cfg |=> (rdata & 32'h00FF_CEEE) == 32'h0000_0000; endproperty
	a_resv: assert property (p_resv) else $error("restart bit reads one");
	property p_mst; rd_cfg |=> rdata[12] == m1_r; endproperty
	a_mst: assert property (p_mst) else $error("master bit");
	property p_zero; rd_cfg && s_r[10:3] == 8'h00 |=> !rdata[13]; endproperty
	a_zero: assert property (p_zero) else $error("hold-off with zero");
	property p_off; calm && !s_r[2] |-> (s_r[0] ? irq_pin_o == !s_r[1] : !irq_pin_oe); endproperty
	a_off: assert property (p_off) else $error("disabled pin active");
	property p_pp; calm && s_r[0] |-> irq_pin_oe; endproperty
	a_pp: assert property (p_pp) else $error("push-pull not driven");
	property p_pol; on && s_r[0] |-> irq_pin_o == s_r[1]; endproperty
	a_pol: assert property (p_pol) else $error("polarity");
	property p_od; on && !s_r[0] |-> irq_pin_oe && !irq_pin_o; endproperty
	a_od: assert property (p_od) else $error("open-drain level");
	c_hold: cover property (rd_cfg ##1 rdata[13]);
	c_pp: cover property (on && s_r[0]);
	c_od: cover property (on && !s_r[0]);
endmodule : irq_pin_monitor
`default_nettype wire

// ==== irq_pin_pkg.sv ====
package irq_pin_pkg;

	// Register access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	// Hold-off sequencer states
	typedef enum logic [1:0] {
		ST_PASS,
		ST_ASSERTED,
		ST_HOLDOFF
	} holdoff_state_t;

endpackage : irq_pin_pkg

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import irq_pin_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        soft_rst = 1'b0;
	logic        pin;
	reg_req_t    req = '0;
	logic [31:0] st = '0;
	logic [31:0] en = '0;
	logic [31:0] rdata;
	logic        irq_pin_o, irq_pin_oe;
	int          failures = 0;
	int          total_checks = 0;
	always #2 core_clk = ~core_clk;
	irq_pin_ctrl irq_pin_ctrl_inst (.core_clk, .rst, .soft_rst, .req, .rdata, .interrupt_source_status(st),
		.interrupt_source_enable(en), .irq_pin_i(pin), .irq_pin_o, .irq_pin_oe);
	irq_host_model irq_host_model_inst (.oe(irq_pin_oe), .o(irq_pin_o), .pin);
	task automatic check(input logic [31:0] seen, exp, input string nm);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// Write is taken on the second edge
	task automatic wr(input logic [31:0] d);
		@(posedge core_clk) req <= '{1'b1, 1'b0, 12'h054, d};
		@(posedge core_clk) req <= '0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] mask, exp, input string nm);
		@(posedge core_clk) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk) req <= '0;
		#1 check(rdata & mask, exp, nm);
	endtask : rd
	task automatic pin_is(input int n, input logic e);
		repeat (n) @(posedge core_clk);
		#1 check({31'h0, pin}, {31'h0, e}, "pin");
	endtask : pin_is
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(12'h054, 32'hFFFF_FFFF, 32'h0, "cfg");
		@(posedge core_clk) st <= 32'h0000_1000;
		rd(12'h054, 32'h0000_1000, 32'h0, "masked");
		@(posedge core_clk) en <= 32'h0000_1000;
		rd(12'h054, 32'h0000_1000, 32'h0000_1000, "master");
		wr(32'h0000_0111);
		// Unmapped offset must read zero even with config bits set
		rd(12'h058, 32'hFFFF_FFFF, 32'h0, "unmapped");
		pin_is(4, 1'b1);
		// Polarity high but open-drain: still driven low
		wr(32'h0000_0110);
		pin_is(4, 1'b0);
		wr(32'h0000_0000);
		pin_is(4, 1'b1);
		wr(32'h0200_0101);
		pin_is(4, 1'b0);
		@(posedge core_clk) st <= 32'h0;
		pin_is(4, 1'b1);
		rd(12'h054, 32'h0000_2000, 32'h0000_2000, "active");
		@(posedge core_clk) st <= 32'h0000_1000;
		wr(32'h0200_4101);
		rd(12'h054, 32'h0000_6000, 32'h0000_2000, "restart");
		// Two whole steps of 2500 cycles from the restart write
		pin_is(4990, 1'b1);
		pin_is(12, 1'b0);
		rd(12'h054, 32'h0000_2000, 32'h0, "ended");
		@(posedge core_clk) st <= 32'h0;
		pin_is(4, 1'b1);
		// New interrupt during hold-off stays off the pin
		@(posedge core_clk) st <= 32'h0000_1000;
		pin_is(2, 1'b1);
		wr(32'h0000_0101);
		pin_is(3, 1'b0);
		wr(32'h0100_0111);
		@(posedge core_clk) soft_rst <= 1'b1;
		@(posedge core_clk) soft_rst <= 1'b0;
		rd(12'h054, 32'hFF00_0111, 32'h0000_0011, "soft");
		summarize();
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge core_clk);
		failures++;
		summarize();
	end
endmodule : tb_top
bind irq_pin_ctrl irq_pin_monitor irq_pin_monitor_inst (.core_clk, .rst, .soft_rst, .req, .rdata,
	.interrupt_source_status, .interrupt_source_enable, .irq_pin_i, .irq_pin_o, .irq_pin_oe);
`default_nettype wire
